// *** scp_strap_config.sv ***
`timescale 1ns/1ps
// Strap capture, power-up sequencing and register port for the disc controller
module scp_strap_config
    import scp_pkg::*;
#(
    parameter int SPIN_GAP = SPINUP_GAP_CYC,
    parameter int FLASH_HALF = FLASH_HALF_CYC,
    parameter int DRIVES = NUM_DRIVES
) (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic [5:0] address_strap_in,
    input wire logic [3:0] address_boot_switch_bank_in,
    input wire logic power_up_utility_select_in,
    input wire logic formatter_revision_select_in,
    input wire logic sequential_spinup_strap_in,
    input wire logic [DRIVES-1:0] motor_ctrl_en_in,
    input wire logic selftest_done_in,
    input wire logic selftest_fail_in,
    input wire logic home_done_in,
    input wire logic geom_valid_in,
    input wire logic [15:0] geom_data_in,
    input wire logic [1:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    output logic [31:0] base_addr_out,
    output logic [1:0] boot_mode_out,
    output logic [23:0] boot_addr_out,
    output logic utility_start_out,
    output logic formatter_new_rev_out,
    output logic [DRIVES-1:0] spin_start_out,
    output logic home_req_out,
    output logic [1:0] geom_drive_out,
    output logic geom_copy_out,
    output logic red_led_out,
    output logic ready_out,
    output logic irq_out
);
    localparam logic [1:0] REG_STATUS = 2'h0;
    localparam logic [1:0] REG_VECTOR = 2'h1;
    localparam logic [1:0] REG_EVENT = 2'h2;
    localparam logic [1:0] REG_MASK = 2'h3;

    logic rst_s1_r, rst_n_r;
    logic in_reset_r;
    logic [5:0] addr_cap_r;
    logic [3:0] boot_cap_r;
    logic util_cap_r, rev_cap_r, seq_cap_r;
    logic [DRIVES-1:0] motor_cap_r;
    scp_state_t state_r;
    logic [31:0] spin_cnt_r, flash_cnt_r;
    logic [1:0] drv_r;
    logic flash_r;
    logic [15:0] sa_r, vector_r;
    logic [2:0] evt_r, mask_r;
    logic [2:0] evt_set;
    logic [DRIVES-1:0] spin_r;
    logic gm_wr;

    // Reset released through two flops
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    // Straps caught while reset held, frozen after release; async clear only sets constants
    always_ff @(posedge ref_clk_in) begin
        in_reset_r <= !rst_n_r;
        if (!rst_n_r) begin // R12
            addr_cap_r <= address_strap_in;
            boot_cap_r <= address_boot_switch_bank_in;
            util_cap_r <= power_up_utility_select_in;
            rev_cap_r <= formatter_revision_select_in;
            seq_cap_r <= sequential_spinup_strap_in;
            motor_cap_r <= motor_ctrl_en_in;
        end
    end

    // One-hot address decode; several on is undefined, lowest wins here
    always_comb begin
        base_addr_out = BASE_ADDR_0; // R1
        if (addr_cap_r[5]) base_addr_out = BASE_ADDR_5;
        if (addr_cap_r[4]) base_addr_out = BASE_ADDR_4;
        if (addr_cap_r[3]) base_addr_out = BASE_ADDR_3;
        if (addr_cap_r[2]) base_addr_out = BASE_ADDR_2;
        if (addr_cap_r[1]) base_addr_out = BASE_ADDR_1;
        if (addr_cap_r[0]) base_addr_out = BASE_ADDR_0;
    end

    // Boot window select; fourth bank position deliberately unread
    always_comb begin
        boot_mode_out = BOOT_MODE_OFF; // R2
        boot_addr_out = 24'h000000;
        if (boot_cap_r[BOOT_LOW_POS]) begin
            boot_mode_out = BOOT_MODE_LOW;
            boot_addr_out = BOOT_LOW_ADDR;
        end
        if (boot_cap_r[BOOT_HIGH_POS]) begin
            boot_mode_out = BOOT_MODE_HIGH;
            boot_addr_out = BOOT_HIGH_ADDR;
        end
        if (boot_cap_r[BOOT_DIS_POS]) begin
            boot_mode_out = BOOT_MODE_OFF;
            boot_addr_out = 24'h000000;
        end
    end

    // Utility only when boot enabled and strap off; strap low means off
    assign utility_start_out = (boot_mode_out != BOOT_MODE_OFF) && !util_cap_r && (state_r == ST_READY); // R3
    assign formatter_new_rev_out = !rev_cap_r; // R4

    // Power-up sequence: test, home, two geometry copies, spin-up
    always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= ST_SELFTEST;
            drv_r <= 2'h0;
            spin_cnt_r <= 32'h0;
        end else begin
            case (state_r)
                ST_SELFTEST: begin // R8
                    if (selftest_done_in) state_r <= selftest_fail_in ? ST_FATAL : ST_HOME;
                end
                ST_FATAL: state_r <= ST_FATAL;
                ST_HOME: begin // R9
                    if (home_done_in) state_r <= ST_GEOM_A;
                end
                ST_GEOM_A: begin
                    if (geom_valid_in) state_r <= ST_GEOM_B;
                end
                ST_GEOM_B: begin
                    if (geom_valid_in) begin
                        if (drv_r == 2'(DRIVES - 1)) begin
                            drv_r <= 2'h0;
                            state_r <= ST_SPIN;
                        end else begin
                            drv_r <= drv_r + 2'h1;
                            state_r <= ST_HOME;
                        end
                    end
                end
                ST_SPIN: begin // R5
                    if (seq_cap_r) state_r <= ST_READY;
                    else if (spin_cnt_r >= 32'(SPIN_GAP - 1)) begin
                        spin_cnt_r <= 32'h0;
                        if (drv_r == 2'(DRIVES - 1)) state_r <= ST_READY;
                        else drv_r <= drv_r + 2'h1;
                    end else spin_cnt_r <= spin_cnt_r + 32'h1;
                end
                ST_READY: state_r <= ST_READY;
                default: state_r <= ST_SELFTEST;
            endcase
        end
    end

    // Drive start enables; strap on releases every drive at once
    always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            spin_r <= '0;
        end else if (seq_cap_r) begin
            spin_r <= '1; // R6
        end else if (state_r == ST_SPIN && spin_cnt_r == 32'h0) begin
            spin_r[drv_r] <= motor_cap_r[drv_r]; // R7
        end
    end
    assign spin_start_out = spin_r;

    assign home_req_out = (state_r == ST_HOME);
    assign geom_drive_out = drv_r;
    assign geom_copy_out = (state_r == ST_GEOM_B);
    assign ready_out = (state_r == ST_READY);
    // Second copy overwrites the first; both copies are read on every power-up that passes self-test
    assign gm_wr = geom_valid_in && (state_r == ST_GEOM_A || state_r == ST_GEOM_B);

    // Red light flash while fatal
    always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            flash_cnt_r <= 32'h0;
            flash_r <= 1'b0;
        end else if (state_r == ST_FATAL) begin // R8
            if (flash_cnt_r >= 32'(FLASH_HALF - 1)) begin
                flash_cnt_r <= 32'h0;
                flash_r <= !flash_r;
            end else flash_cnt_r <= flash_cnt_r + 32'h1;
        end
    end
    assign red_led_out = flash_r;

    // Events: fatal, geometry recovered, ready reached through unsequenced spin-up
    // Fatal is flagged on entry only; a level would set the bit again every cycle
    // and software could never clear it while the light flashes
    assign evt_set = {state_r == ST_SPIN && seq_cap_r, gm_wr,
                      state_r == ST_SELFTEST && selftest_done_in && selftest_fail_in};

    // Status, vector and interrupt registers; set beats write-one clear
    always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            sa_r <= 16'h0000;
            vector_r <= 16'h0000;
            evt_r <= 3'h0;
            mask_r <= 3'h0;
        end else begin
            if (state_r == ST_FATAL) sa_r <= FATAL_STATUS; // R8
            if (reg_wr_in && reg_addr_in == REG_VECTOR) vector_r <= reg_wdata_in; // R10
            if (reg_wr_in && reg_addr_in == REG_MASK) mask_r <= reg_wdata_in[2:0];
            if (reg_wr_in && reg_addr_in == REG_EVENT) evt_r <= (evt_r & ~reg_wdata_in[2:0]) | evt_set;
            else evt_r <= evt_r | evt_set;
        end
    end
    assign irq_out = |(evt_r & mask_r);

    // Read data one cycle after strobe; one access per strobe, never overlapped
    always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin // R11
            case (reg_addr_in)
                REG_STATUS: reg_rdata_out <= sa_r;
                REG_VECTOR: reg_rdata_out <= vector_r;
                REG_EVENT: reg_rdata_out <= {13'h0, evt_r};
                REG_MASK: reg_rdata_out <= {13'h0, mask_r};
                default: reg_rdata_out <= 16'h0000;
            endcase
        end else begin
            reg_rdata_out <= 16'h0000;
        end
    end

    scp_geom_mem #(.WIDTH(16), .DEPTH(4)) u_geom (
        .clk_in(ref_clk_in),
        .wr_en_in(gm_wr),
        .wr_addr_in(drv_r),
        .wr_data_in(geom_data_in),
        .rd_addr_in(drv_r),
        .rd_data_out()
    );

    // Checks
    // Steps of the geometry walk, one per drive-side handshake
    sequence seq_home_done;
        state_r == ST_HOME && home_done_in;
    endsequence
    sequence seq_copy_a;
        state_r == ST_GEOM_A && geom_valid_in;
    endsequence
    sequence seq_copy_b;
        state_r == ST_GEOM_B && geom_valid_in;
    endsequence

    AST_FATAL_STATUS: assert property (@(posedge ref_clk_in) disable iff (!rst_n_r) // R8
        state_r == ST_FATAL |=> sa_r == FATAL_STATUS) else $error("fatal status not posted");
    AST_NO_SEQ_ALL: assert property (@(posedge ref_clk_in) disable iff (!rst_n_r) // R6
        seq_cap_r && !in_reset_r |=> spin_start_out == '1) else $error("drives held with strap on");
    AST_MOTOR_ONLY: assert property (@(posedge ref_clk_in) disable iff (!rst_n_r) // R7
        !seq_cap_r |-> (spin_start_out & ~motor_cap_r) == '0) else $error("drive without option started");
    AST_ONE_AT_TIME: assert property (@(posedge ref_clk_in) disable iff (!rst_n_r) // R5
        !seq_cap_r |-> $countones(spin_start_out ^ $past(spin_start_out)) <= 1) else $error("two drives started");
    AST_STRAP_HOLD: assert property (@(posedge ref_clk_in) disable iff (!rst_n_r || in_reset_r) // R12
        $stable(addr_cap_r) && $stable(seq_cap_r)) else $error("strap copy changed");
    AST_BOOT_OFF: assert property (@(posedge ref_clk_in) disable iff (!rst_n_r) // R2
        boot_cap_r[BOOT_DIS_POS] |-> boot_mode_out == BOOT_MODE_OFF) else $error("boot not disabled");
    AST_UTIL: assert property (@(posedge ref_clk_in) disable iff (!rst_n_r) // R3
        utility_start_out |-> !util_cap_r && boot_mode_out != BOOT_MODE_OFF) else $error("utility wrongly started");
    AST_HOME_FIRST: assert property (@(posedge ref_clk_in) disable iff (!rst_n_r) // R9
        seq_home_done |=> state_r == ST_GEOM_A) else $error("geometry read skipped");

    // Drive walk: both stored copies read before the next drive is homed
    AST_COPY_A_THEN_B: assert property (@(posedge ref_clk_in) disable iff (!rst_n_r) // R9
        seq_copy_a |=> state_r == ST_GEOM_B && drv_r == $past(drv_r))
        else $error("second geometry copy skipped");
    AST_NEXT_DRIVE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_r) // R9
        seq_copy_b ##0 drv_r != 2'(DRIVES - 1) |=> state_r == ST_HOME && drv_r == $past(drv_r) + 2'h1)
        else $error("next drive not homed");
    AST_SPIN_LAST: assert property (@(posedge ref_clk_in) disable iff (!rst_n_r) // R5
        seq_copy_b ##0 drv_r == 2'(DRIVES - 1) |=> state_r == ST_SPIN && drv_r == 2'h0)
        else $error("spin-up not entered after last drive");

    // Spin-up: sequenced starts only on a gap boundary, unsequenced flagged once
    AST_SPIN_GAP: assert property (@(posedge ref_clk_in) disable iff (!rst_n_r) // R5
        !seq_cap_r && spin_start_out != $past(spin_start_out)
        |-> $past(state_r) == ST_SPIN && $past(spin_cnt_r) == 32'h0)
        else $error("drive started off the gap boundary");
    AST_READY_EVENT: assert property (@(posedge ref_clk_in) disable iff (!rst_n_r) // R6
        state_r == ST_SPIN && seq_cap_r |=> state_r == ST_READY && evt_r[2])
        else $error("unsequenced ready not flagged");

    // Self-test failure flagged; light moves only while fatal; read data one cycle
    AST_FATAL_EVENT: assert property (@(posedge ref_clk_in) disable iff (!rst_n_r) // R8
        state_r == ST_SELFTEST && selftest_done_in && selftest_fail_in |=> state_r == ST_FATAL && evt_r[0])
        else $error("fatal event not flagged");
    AST_LED_FATAL_ONLY: assert property (@(posedge ref_clk_in) disable iff (!rst_n_r) // R8
        $changed(red_led_out) |-> $past(state_r) == ST_FATAL) else $error("red light moved outside fatal");
    AST_RDATA_IDLE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_r) // R11
        !$past(reg_rd_in) |-> reg_rdata_out == 16'h0000) else $error("read data outside its cycle");
endmodule

// *** scp_pkg.sv ***
// Package of constants for the strap configuration power-up block
// Contract
// R1 - Decode six-way one-hot address strap into one of six base register addresses
// R2 - Three-way one-hot boot strap: disabled, high window or low window; fourth ignored
// R3 - Boot enabled: utility strap off starts maintenance utility, on is normal power-up
// R4 - Revision strap off means newer formatter fitted, on means older
// R5 - Spin-up strap off: start drives one after another, never together
// R6 - Spin-up strap on: all drives may start as soon as powered
// R7 - Sequence only drives whose motor-control option is enabled
// R8 - Self-test at power-up; failure flashes red light and posts fatal status
// R9 - Every power-up home heads and read duplicated geometry from track zero; skipped after a failed self-test
// R10 - No interrupt vector strap; host software supplies the vector
// R11 - No new host bus transaction until the previous one completes
// R12 - Sample straps once during reset, hold them until next reset
package scp_pkg;
    localparam int NUM_DRIVES = 4;
    localparam int NUM_BASE = 6;
    localparam logic [31:0] BASE_ADDR_0 = 32'h20001468;
    localparam logic [31:0] BASE_ADDR_1 = 32'h200000dc;
    localparam logic [31:0] BASE_ADDR_2 = 32'h200000ec;
    localparam logic [31:0] BASE_ADDR_3 = 32'h200000fc;
    localparam logic [31:0] BASE_ADDR_4 = 32'h2000010c;
    localparam logic [31:0] BASE_ADDR_5 = 32'h2000011c;
    // Boot windows are octal 17773000 and 17771000 on the 22-bit bus, held here in hex
    localparam logic [23:0] BOOT_HIGH_ADDR = 24'h3ff600;
    localparam logic [23:0] BOOT_LOW_ADDR = 24'h3ff200;
    // Boot strap bank positions
    localparam int BOOT_DIS_POS = 0;
    localparam int BOOT_HIGH_POS = 1;
    localparam int BOOT_LOW_POS = 2;
    localparam logic [1:0] BOOT_MODE_OFF = 2'h0;
    localparam logic [1:0] BOOT_MODE_HIGH = 2'h1;
    localparam logic [1:0] BOOT_MODE_LOW = 2'h2;
    // Fatal status pattern posted to the host-visible status word
    localparam logic [15:0] FATAL_STATUS = 16'h8000;
    // Timing, in microseconds at 20 MHz
    localparam int CLK_MHZ = 20;
    localparam int SPINUP_GAP_US = 1000;
    localparam int SPINUP_GAP_CYC = SPINUP_GAP_US * CLK_MHZ;
    localparam int FLASH_HALF_US = 250000;
    localparam int FLASH_HALF_CYC = FLASH_HALF_US * CLK_MHZ;
    typedef enum logic [6:0] {
        ST_SELFTEST = 7'h01,
        ST_FATAL = 7'h02,
        ST_HOME = 7'h04,
        ST_GEOM_A = 7'h08,
        ST_GEOM_B = 7'h10,
        ST_SPIN = 7'h20,
        ST_READY = 7'h40
    } scp_state_t;
endpackage

// *** scp_geom_mem.sv ***
`timescale 1ns/1ps
// Small memory holding the recovered geometry word per drive
module scp_geom_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic clk_in,
    input wire logic wr_en_in,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
    output logic [WIDTH-1:0] rd_data_out
);
    logic [WIDTH-1:0] mem [DEPTH];
    // Write port and registered read
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem[rd_addr_in];
    end
endmodule

// *** scp_host_model.sv ***
`timescale 1ns/1ps
// Host processor model that drives the register port
module scp_host_model (
    input wire logic clk_in,
    input wire logic [15:0] rdata_in,
    output logic [1:0] addr_out,
    output logic [15:0] wdata_out,
    output logic wr_out,
    output logic rd_out
);
    // Idle bus at time zero
    initial begin
        addr_out = 2'h0;
        wdata_out = 16'h0000;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // One cycle write; stale data inverted so nothing passes by luck
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        wdata_out <= ~d;
    endtask
    // Read data taken in the single cycle after the strobe
    task automatic rd(input logic [1:0] a, output logic [15:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        #1;
        d = rdata_in;
    endtask
endmodule

// *** scp_strap_config_tb.sv ***
`timescale 1ns/1ps
// Testbench: strap decode, power-up walk, fatal path and registers
module scp_strap_config_tb;
    import scp_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [5:0] astrap = 6'h01;
    logic [3:0] bank = 4'h1, motor = 4'hb, spin, spin_prev;
    logic util = 1'b1, rev = 1'b0, seqs = 1'b0, st_fail = 1'b0, hdone = 1'b0, gvalid = 1'b0;
    logic [15:0] gdata = 16'h0000, rdata, rdat, wdata;
    logic [1:0] raddr, bmode, gdrive;
    logic wr, rd, util_st, new_rev, hreq, gcopy, red, rdy, irq, a, b, led_prev;
    logic [31:0] base;
    logic [23:0] baddr;
    int n_mismatch = 0, tests_run = 0, max_new = 0;
    logic [31:0] base_tab [6] = '{BASE_ADDR_0, BASE_ADDR_1, BASE_ADDR_2, BASE_ADDR_3, BASE_ADDR_4, BASE_ADDR_5};
    initial begin
        forever #25 clk = ~clk;
    end
    // Short counts keep the run brief
    scp_strap_config #(.SPIN_GAP(4), .FLASH_HALF(4), .DRIVES(4)) uut (
        .ref_clk_in(clk), .arst_n_in(arst_n), .address_strap_in(astrap),
        .address_boot_switch_bank_in(bank), .power_up_utility_select_in(util),
        .formatter_revision_select_in(rev), .sequential_spinup_strap_in(seqs),
        .motor_ctrl_en_in(motor), .selftest_done_in(1'b1), .selftest_fail_in(st_fail),
        .home_done_in(hdone), .geom_valid_in(gvalid), .geom_data_in(gdata),
        .reg_addr_in(raddr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .base_addr_out(base), .boot_mode_out(bmode),
        .boot_addr_out(baddr), .utility_start_out(util_st), .formatter_new_rev_out(new_rev),
        .spin_start_out(spin), .home_req_out(hreq), .geom_drive_out(gdrive),
        .geom_copy_out(gcopy), .red_led_out(red), .ready_out(rdy), .irq_out(irq));
    scp_host_model host (.clk_in(clk), .rdata_in(rdata), .addr_out(raddr),
        .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
    // Widest burst of drives started in one cycle
    always @(negedge clk) begin
        spin_prev <= spin;
        if (!arst_n) max_new <= 0;
        else if ($countones(spin & ~spin_prev) > max_new) max_new <= $countones(spin & ~spin_prev);
    end
    task automatic finish_test;
        $display("Mismatches %0d of %0d comparisons", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    function automatic bit cond(input int c);
        case (c)
            0: return hreq === 1'b1;
            1: return rdy === 1'b1;
            default: return red !== led_prev;
        endcase
    endfunction
    // Bounded wait; a hang ends the run
    task automatic wait_for(input int c);
        int k;
        k = 0;
        while (!cond(c)) begin
            step();
            k++;
            if (k > 200) begin
                n_mismatch++;
                $display("[ERR] %0t wait timed out", $time);
                finish_test();
            end
        end
    endtask
    // Straps are held steady through reset
    task automatic reset_dut;
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
    endtask
    // Drive-side walk: home, two geometry copies per drive, then spin-up
    task automatic power_up(input logic eu, input logic so);
        for (int d = 0; d < 4; d++) begin
            wait_for(0);
            @(posedge clk);
            hdone <= 1'b1;
            gdata <= 16'(d + 16'h0100);
            @(posedge clk);
            hdone <= 1'b0;
            for (int c = 0; c < 2; c++) begin
                step();
                chk(gdrive, d);
                chk(gcopy, c);
                @(posedge clk);
                gvalid <= 1'b1;
                @(posedge clk);
                gvalid <= 1'b0;
            end
        end
        wait_for(1);
        chk(spin & motor, motor);
        chk(util_st, eu);
        chk(red, 0);
        if (so) chk(max_new >= 3, 1);
        else chk(max_new, 1);
        if (!so) chk(spin[2], 0);
    endtask
    initial begin
        reset_dut();
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            astrap <= 6'h01 << i;
            bank <= (4'h1 << (i % 3)) | (i[0] ? 4'h8 : 4'h0);
            util <= i[1];
            rev <= i[0];
            seqs <= i[0];
            reset_dut();
            @(posedge clk);
            astrap <= 6'h3f;
            bank <= 4'hf;
            util <= !i[1];
            rev <= !i[0];
            seqs <= !i[0];
            step();
            chk(base, base_tab[i]);
            chk(bmode, i % 3);
            if (i % 3 != 0) chk(baddr, (i % 3 == 1) ? BOOT_HIGH_ADDR : BOOT_LOW_ADDR);
            chk(new_rev, !i[0]);
            power_up((i % 3 != 0) && !i[1], i[0]);
        end
        @(posedge clk);
        st_fail <= 1'b1;
        reset_dut();
        led_prev = red;
        wait_for(2);
        led_prev = red;
        wait_for(2);
        host.rd(2'h0, rdat);
        chk(rdat, FATAL_STATUS);
        step();
        chk(rdata, 0);
        host.wr(2'h0, 16'h0000);
        host.rd(2'h0, rdat);
        chk(rdat, FATAL_STATUS);
        host.wr(2'h1, 16'h00a5);
        host.rd(2'h1, rdat);
        chk(rdat, 16'h00a5);
        host.rd(2'h2, rdat);
        chk(rdat[0], 1);
        host.wr(2'h3, 16'h0000);
        step();
        a = irq;
        host.wr(2'h3, 16'h0007);
        step();
        b = irq;
        chk(a ^ b, 1);
        host.wr(2'h3, a ? 16'h0000 : 16'h0007);
        host.wr(2'h2, 16'h0001);
        step();
        chk(irq, 0);
        host.rd(2'h2, rdat);
        chk(rdat[0], 0);
        finish_test();
    end
endmodule
